// ===== logic/gdc_pkg.sv
/*
 * Shared constants and types for the pin and converter control block.
 * Assumes one 200 MHz clock and a 32-bit AHB-Lite register bus.
 */
package gdc_pkg;

	// Register indices; the byte address is four times the index.
	localparam logic [7:0] IDX_IOCFG = 8'h0E;
	localparam logic [7:0] IDX_CONVCFG = 8'h0F;
	localparam logic [7:0] IDX_TRIM = 8'h10;
	localparam logic [7:0] IDX_RESULT = 8'h11;
	localparam logic [7:0] IDX_FSEL = 8'h40;
	localparam logic [7:0] IDX_IRQSTAT = 8'h41;
	localparam logic [7:0] IDX_IRQMASK = 8'h42;

	// Field positions.
	localparam int IO_EXT_LSB = 4;
	localparam int IO_IRQ_SDO_BIT = 3;
	localparam int CONV_START_BIT = 7;
	localparam int CONV_SEL_LSB = 4;
	localparam int CONV_REF_LSB = 2;
	localparam int CONV_GAIN_LSB = 0;
	localparam int FSEL_STRIDE = 8;
	localparam int IRQ_DONE_BIT = 3;

	// Values after reset.
	localparam logic [3:0] IOCFG_RESET = 4'h0;
	localparam logic [6:0] CONVCFG_RESET = 7'h00;
	localparam logic [3:0] TRIM_RESET = 4'h0;
	localparam logic [4:0] FSEL_RESET = 5'h00;

	// Pin function codes.
	localparam logic [4:0] FSEL_DIN = 5'h02;
	localparam logic [4:0] FSEL_EXT_FALL = 5'h04;
	localparam logic [4:0] FSEL_EXT_RISE = 5'h05;
	localparam logic [4:0] FSEL_EXT_ANY = 5'h06;
	localparam logic [4:0] FSEL_ANALOG = 5'h07;
	localparam logic [4:0] FSEL_DOUT = 5'h0A;

	// Converter input codes.
	localparam logic [2:0] SEL_TEMP = 3'h0;
	localparam logic [2:0] SEL_DIFF01 = 3'h4;
	localparam logic [2:0] SEL_DIFF12 = 3'h5;
	localparam logic [2:0] SEL_DIFF02 = 3'h6;
	localparam logic [2:0] SEL_GND = 3'h7;

	// Conversion time and its cycle count, rounded up.
	localparam int CLK_MHZ = 200;
	localparam int CONV_TIME_NS = 1000;
	localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;

	// Settings handed to the analog front end.
	typedef struct packed {
		logic [2:0] inputSel;
		logic [1:0] refSel;
		logic [1:0] gain;
		logic [3:0] offsetTrim;
		logic diffMode;
		logic refBandgap;
		logic gainStepHigh;
	} gdc_analog_ctrl_t;

	// True when a function code makes the pin an external interrupt input.
	function automatic logic isExtIrq(input logic [4:0] fsel);
		isExtIrq = (fsel == FSEL_EXT_FALL) || (fsel == FSEL_EXT_RISE) || (fsel == FSEL_EXT_ANY);
	endfunction : isExtIrq

	// True for the three differential input codes.
	function automatic logic isDiff(input logic [2:0] sel);
		isDiff = (sel == SEL_DIFF01) || (sel == SEL_DIFF12) || (sel == SEL_DIFF02);
	endfunction : isDiff

endpackage : gdc_pkg

// ===== logic/gdc_conv_seq.sv
/*
 * Converter sequencer: runs one measurement cycle per start pulse and keeps the result.
 * Assumes the analog front end holds a settled code on sampleCode at the cycle's end.
 */
`timescale 1ns/1ps
`default_nettype none

module gdc_conv_seq (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Control.
	input wire logic startPulse,
	input wire logic [7:0] sampleCode,
	// Status and result.
	output logic busy,
	output logic donePulse,
	output logic [7:0] result
);

	localparam logic [8:0] CYC = 9'(gdc_pkg::CONV_CYCLES);
	// The done pulse is registered one edge after the count runs out, hence the extra cycle.
	localparam int WAIT_CYC = gdc_pkg::CONV_CYCLES + 1;

	typedef enum logic {GDC_IDLE, GDC_RUN} gdc_seq_state_t;

	gdc_seq_state_t state, next_state;
	logic [8:0] count, next_count;
	logic [7:0] next_result;
	logic next_donePulse;

	// A start during a running cycle is ignored so a result is never torn.
	always_comb begin
		next_state = state;
		next_count = count;
		next_result = result;
		next_donePulse = 1'b0;
		case (state)
			GDC_IDLE: begin
				if (startPulse) begin // RULE5
					next_state = GDC_RUN;
					next_count = CYC - 9'h001;
				end
			end
			GDC_RUN: begin
				if (count == 9'h000) begin
					next_state = GDC_IDLE;
					next_result = sampleCode; // RULE13
					next_donePulse = 1'b1; // RULE6
				end else begin
					next_count = count - 9'h001;
				end
			end
			default: next_state = GDC_IDLE;
		endcase
	end

	// State registers.
	always_ff @(posedge clk) begin
		if (reset) begin
			state <= GDC_IDLE;
			count <= 9'h000;
			result <= 8'h00;
			donePulse <= 1'b0;
		end else begin
			state <= next_state;
			count <= next_count;
			result <= next_result;
			donePulse <= next_donePulse;
		end
	end

	assign busy = (state == GDC_RUN);

	property p_done_time;
		@(posedge clk) disable iff (reset)
		(startPulse && !busy) |-> ##WAIT_CYC donePulse;
	endproperty
	a_done_time: assert property (p_done_time) else $error("Conversion end mistimed."); // RULE6

	property p_result_hold;
		@(posedge clk) disable iff (reset)
		!next_donePulse |=> $stable(result);
	endproperty
	a_result_hold: assert property (p_result_hold) else $error("Result changed early."); // RULE13

endmodule : gdc_conv_seq

`default_nettype wire

// ===== logic/gdc_regs.sv
/*
 * Register bank for the three general pins and the 8-bit converter, AHB-Lite slave.
 * Assumes pin inputs synchronous to clk and one bus master with zero-wait answers.
 */
// Notes on behaviour
// RULE1 - Pins set as external interrupts show their status in bits 6, 5, 4.
// RULE2 - With bit 3 set and select high, the interrupt request drives data out.
// RULE3 - A direct output pin follows its direct I/O bit.
// RULE4 - Reading a direct input pin's bit returns the pin's sampled level.
// RULE5 - Writing one to converter bit 7 starts a measurement cycle.
// RULE6 - Start/done bit reads one once the measurement cycle has finished.
// RULE7 - Input codes 000 temperature, 001-011 pins single-ended, 111 ground.
// RULE8 - Codes 100, 101, 110 pick differential pin pairs 0-1, 1-2, 0-2.
// RULE9 - Reference field: 0X bandgap, 10 third of supply, 11 half supply.
// RULE10 - Differential full scale is (gain+1) times supply times 0.014 or 0.021.
// RULE11 - Offset trim: bit 3 sign, bits 2:0 magnitude; upper bits reserved.
// RULE12 - The 8-bit result register is read-only; writes do nothing.
// RULE13 - The result holds until the next measurement cycle finishes.
// RULE14 - Function codes 00100 and 00101 make falling and rising edge interrupts.
// RULE15 - Function code 00010 makes the pin a direct digital input.
// RULE16 - Function code 00111 routes the pin to the converter as analog input.
`timescale 1ns/1ps
`default_nettype none

module gdc_regs (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// General pins.
	input wire logic [2:0] gpioIn,
	output logic [2:0] gpioOut,
	output logic [2:0] gpioOe,
	output logic [2:0] analogRouteEn,
	// Serial data out sharing.
	input wire logic chip_select_n,
	input wire logic spiSdo,
	input wire logic spiSdoOe,
	output logic sdoOut,
	output logic sdoOe,
	// Converter front end.
	input wire logic [7:0] sampleCode,
	output gdc_pkg::gdc_analog_ctrl_t analogCtrl,
	// Interrupt.
	output logic irqRequestN
);

	logic [4:0] fsel [3];
	logic [4:0] next_fsel [3];
	logic [2:0] direct_io_pin, next_direct_io_pin;
	logic [2:0] extStatus, next_extStatus;
	logic irqOnSdo, next_irqOnSdo;
	logic [6:0] convCfg, next_convCfg;
	logic [3:0] trim, next_trim;
	logic doneFlag, next_doneFlag;
	logic [3:0] irqStat, next_irqStat;
	logic [3:0] irqMask, next_irqMask;
	logic [2:0] pinSample, next_pinSample;
	logic dpWrite, next_dpWrite;
	logic [7:0] dpIndex, next_dpIndex;
	logic [31:0] next_hrdata;
	logic startPulse, convBusy, convDone;
	logic [7:0] result;
	logic [2:0] extEvent;
	logic addrTake, readTake, irqLevel;

	// Full-word index decode; anything outside the low window is unmapped.
	function automatic logic [7:0] regIndex(input logic [31:0] a);
		regIndex = (a[31:10] == 22'h0 && a[1:0] == 2'h0) ? a[9:2] : 8'hFF;
	endfunction : regIndex

	gdc_conv_seq u_seq (
		.clk(clk),
		.reset(reset),
		.startPulse(startPulse),
		.sampleCode(sampleCode),
		.busy(convBusy),
		.donePulse(convDone),
		.result(result)
	);

	assign addrTake = hsel && htrans[1] && hready;
	assign readTake = addrTake && !hwrite;
	assign startPulse = dpWrite && dpIndex == gdc_pkg::IDX_CONVCFG &&
		hwdata[gdc_pkg::CONV_START_BIT]; // RULE5

	// Edge detection on pins set as external interrupts.
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			case (fsel[i])
				gdc_pkg::FSEL_EXT_FALL: extEvent[i] = pinSample[i] && !gpioIn[i]; // RULE14
				gdc_pkg::FSEL_EXT_RISE: extEvent[i] = !pinSample[i] && gpioIn[i]; // RULE14
				gdc_pkg::FSEL_EXT_ANY: extEvent[i] = pinSample[i] != gpioIn[i];
				default: extEvent[i] = 1'b0;
			endcase
		end
	end

	// Register next values: bus writes in the data phase, reads in the address phase.
	// Every hardware set wins over a clear landing in the same cycle.
	always_comb begin
		logic [2:0] pinRead;
		pinRead = 3'h0;
		next_fsel = fsel;
		next_direct_io_pin = direct_io_pin;
		next_irqOnSdo = irqOnSdo;
		next_convCfg = convCfg;
		next_trim = trim;
		next_irqMask = irqMask;
		next_irqStat = irqStat;
		next_extStatus = extStatus;
		next_doneFlag = doneFlag;
		next_pinSample = gpioIn;
		next_dpWrite = addrTake && hwrite;
		next_dpIndex = addrTake ? regIndex(haddr) : 8'hFF;
		next_hrdata = 32'h0000_0000;
		for (int i = 0; i < 3; i++) begin
			pinRead[i] = (fsel[i] == gdc_pkg::FSEL_DIN) ? pinSample[i] : direct_io_pin[i]; // RULE4 RULE15
		end
		if (dpWrite) begin
			case (dpIndex)
				gdc_pkg::IDX_IOCFG: begin
					next_direct_io_pin = hwdata[2:0]; // RULE3
					next_irqOnSdo = hwdata[gdc_pkg::IO_IRQ_SDO_BIT];
				end
				gdc_pkg::IDX_CONVCFG: begin
					next_convCfg = hwdata[6:0];
					if (startPulse && !convBusy) begin
						next_doneFlag = 1'b0;
					end
				end
				gdc_pkg::IDX_TRIM: next_trim = hwdata[3:0]; // RULE11
				gdc_pkg::IDX_FSEL: begin
					for (int i = 0; i < 3; i++) begin
						next_fsel[i] = hwdata[i * gdc_pkg::FSEL_STRIDE +: 5];
					end
				end
				gdc_pkg::IDX_IRQSTAT: next_irqStat = irqStat & ~hwdata[3:0];
				gdc_pkg::IDX_IRQMASK: next_irqMask = hwdata[3:0];
				default: next_irqMask = irqMask; // Result and unmapped writes are dropped. RULE12
			endcase
		end
		if (readTake) begin
			case (regIndex(haddr))
				gdc_pkg::IDX_IOCFG: begin
					next_hrdata = {24'h0, 1'b0, extStatus, irqOnSdo, pinRead}; // RULE1
					next_extStatus = 3'h0; // Reading clears the pin status.
				end
				gdc_pkg::IDX_CONVCFG: next_hrdata = {24'h0, doneFlag, convCfg}; // RULE6
				gdc_pkg::IDX_TRIM: next_hrdata = {28'h0, trim};
				gdc_pkg::IDX_RESULT: next_hrdata = {24'h0, result}; // RULE12
				gdc_pkg::IDX_FSEL: next_hrdata = {11'h0, fsel[2], 3'h0, fsel[1], 3'h0, fsel[0]};
				gdc_pkg::IDX_IRQSTAT: next_hrdata = {28'h0, irqStat};
				gdc_pkg::IDX_IRQMASK: next_hrdata = {28'h0, irqMask};
				default: next_hrdata = 32'h0000_0000;
			endcase
		end
		for (int i = 0; i < 3; i++) begin
			if (extEvent[i] && gdc_pkg::isExtIrq(fsel[i])) begin
				next_extStatus[i] = 1'b1; // RULE1
				next_irqStat[i] = 1'b1;
			end
		end
		if (convDone) begin
			next_doneFlag = 1'b1; // RULE6
			next_irqStat[gdc_pkg::IRQ_DONE_BIT] = 1'b1;
		end
	end

	// Register storage.
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < 3; i++) begin
				fsel[i] <= gdc_pkg::FSEL_RESET;
			end
			direct_io_pin <= gdc_pkg::IOCFG_RESET[2:0];
			irqOnSdo <= gdc_pkg::IOCFG_RESET[3];
			convCfg <= gdc_pkg::CONVCFG_RESET;
			trim <= gdc_pkg::TRIM_RESET;
			doneFlag <= 1'b1; // Idle converter reads as finished.
			irqStat <= 4'h0;
			irqMask <= 4'h0;
			extStatus <= 3'h0;
			pinSample <= 3'h0;
			dpWrite <= 1'b0;
			dpIndex <= 8'hFF;
			hrdata <= 32'h0000_0000;
		end else begin
			fsel <= next_fsel;
			direct_io_pin <= next_direct_io_pin;
			irqOnSdo <= next_irqOnSdo;
			convCfg <= next_convCfg;
			trim <= next_trim;
			doneFlag <= next_doneFlag;
			irqStat <= next_irqStat;
			irqMask <= next_irqMask;
			extStatus <= next_extStatus;
			pinSample <= next_pinSample;
			dpWrite <= next_dpWrite;
			dpIndex <= next_dpIndex;
			hrdata <= next_hrdata;
		end
	end

	// Pin drive: only direct outputs drive; analog pins are routed to the converter.
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			gpioOe[i] = (fsel[i] == gdc_pkg::FSEL_DOUT);
			gpioOut[i] = gpioOe[i] && direct_io_pin[i]; // RULE3
			analogRouteEn[i] = (fsel[i] == gdc_pkg::FSEL_ANALOG); // RULE16
		end
	end

	// Front-end settings; the analog side interprets codes, this side only decodes modes.
	assign analogCtrl.inputSel = convCfg[gdc_pkg::CONV_SEL_LSB +: 3]; // RULE7
	assign analogCtrl.diffMode = gdc_pkg::isDiff(analogCtrl.inputSel); // RULE8
	assign analogCtrl.refSel = convCfg[gdc_pkg::CONV_REF_LSB +: 2];
	assign analogCtrl.refBandgap = !analogCtrl.refSel[1]; // RULE9
	assign analogCtrl.gain = convCfg[gdc_pkg::CONV_GAIN_LSB +: 2]; // RULE10
	assign analogCtrl.gainStepHigh = analogCtrl.refSel[0]; // RULE10
	assign analogCtrl.offsetTrim = trim; // RULE11

	// Interrupt and its optional route onto the serial data pin.
	assign irqLevel = |(irqStat & irqMask);
	assign irqRequestN = !irqLevel;
	assign sdoOut = (irqOnSdo && chip_select_n) ? irqRequestN : spiSdo; // RULE2
	assign sdoOe = (irqOnSdo && chip_select_n) || spiSdoOe; // RULE2

	// Always ready, always OKAY.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	property p_ext_status;
		@(posedge clk) disable iff (reset)
		(extEvent[0] && gdc_pkg::isExtIrq(fsel[0])) |=> extStatus[0] && irqStat[0];
	endproperty
	a_ext_status: assert property (p_ext_status) else $error("Pin 0 status not set."); // RULE1

	property p_sdo_irq;
		@(posedge clk) disable iff (reset)
		(irqOnSdo && chip_select_n) |-> (sdoOe && sdoOut == !(|(irqStat & irqMask)));
	endproperty
	a_sdo_irq: assert property (p_sdo_irq) else $error("Request not on data out."); // RULE2

	property p_direct_out;
		@(posedge clk) disable iff (reset)
		(dpWrite && dpIndex == gdc_pkg::IDX_IOCFG && fsel[1] == gdc_pkg::FSEL_DOUT && $stable(fsel[1]))
		|=> (gpioOe[1] && gpioOut[1] == $past(hwdata[1]));
	endproperty
	a_direct_out: assert property (p_direct_out) else $error("Pin 1 not driven."); // RULE3

	property p_direct_in;
		@(posedge clk) disable iff (reset)
		(readTake && regIndex(haddr) == gdc_pkg::IDX_IOCFG && fsel[2] == gdc_pkg::FSEL_DIN)
		|=> hrdata[2] == $past(pinSample[2]);
	endproperty
	a_direct_in: assert property (p_direct_in) else $error("Pin 2 level misread."); // RULE4

	property p_start;
		@(posedge clk) disable iff (reset)
		(startPulse && !convBusy) |=> (convBusy && !doneFlag) [*2];
	endproperty
	a_start: assert property (p_start) else $error("Start did not begin a cycle."); // RULE5

	property p_diff_mode;
		@(posedge clk) disable iff (reset)
		analogCtrl.diffMode == (convCfg[6] && convCfg[5:4] != 2'h3);
	endproperty
	a_diff_mode: assert property (p_diff_mode) else $error("Differential decode wrong."); // RULE8

	property p_result_ro;
		@(posedge clk) disable iff (reset)
		(dpWrite && dpIndex == gdc_pkg::IDX_RESULT && !convDone) |=> $stable(result);
	endproperty
	a_result_ro: assert property (p_result_ro) else $error("Result took a write."); // RULE12

	property p_irq_level;
		@(posedge clk) disable iff (reset)
		(convDone && irqMask[gdc_pkg::IRQ_DONE_BIT]) |=> !irqRequestN;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("Done interrupt missing."); // RULE6

	// A rising edge on a rise source must flag even when a status read lands alongside.
	property p_rise_edge;
		@(posedge clk) disable iff (reset)
		(fsel[1] == gdc_pkg::FSEL_EXT_RISE && !pinSample[1] && gpioIn[1]) |=> extStatus[1];
	endproperty
	a_rise_edge: assert property (p_rise_edge) else $error("Pin 1 rise not flagged."); // RULE14

	property p_trim_reserved;
		@(posedge clk) disable iff (reset)
		(readTake && regIndex(haddr) == gdc_pkg::IDX_TRIM) |=> (hrdata[31:4] == 28'h0);
	endproperty
	a_trim_reserved: assert property (p_trim_reserved) else $error("Trim upper bits set."); // RULE11

endmodule : gdc_regs

`default_nettype wire

// ===== tb/gdc_front_model.sv
/*
 * Model of what surrounds the block: the three pins and the analog converter front end.
 * Assumes the bench drives the pin levels wherever the block itself does not drive a pin.
 */
`timescale 1ns/1ps
`default_nettype none

module gdc_front_model (
	// Settings from the block.
	input wire gdc_pkg::gdc_analog_ctrl_t analogCtrl,
	input wire logic [2:0] gpioOut,
	input wire logic [2:0] gpioOe,
	// Levels from the bench.
	input wire logic [2:0] pinDrive,
	// Answers to the block.
	output logic [2:0] gpioIn,
	output logic [7:0] sampleCode
);
	// A driven pin reads back its own level; an undriven one follows the bench.
	assign gpioIn = (gpioOe & gpioOut) | (~gpioOe & pinDrive);
	// The code mirrors every analog setting but refBandgap and gainStepHigh, so a misrouted field shows up in the result.
	assign sampleCode = {analogCtrl.inputSel, analogCtrl.refSel, analogCtrl.gain,
		analogCtrl.diffMode} ^ {analogCtrl.offsetTrim, 4'h0};
endmodule : gdc_front_model

`default_nettype wire

// ===== tb/tb.sv
/*
 * Self-checking bench for the pin and converter register block.
 * Assumes the front-end model beside it and a zero-wait AHB-Lite slave.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [2:0] gpioIn;
	logic [2:0] gpioOut;
	logic [2:0] gpioOe;
	logic [2:0] analogRouteEn;
	logic [2:0] pinDrive = 3'h0;
	logic chipSelectN = 1'b1;
	logic spiSdo = 1'b0;
	logic spiSdoOe = 1'b0;
	logic sdoOut;
	logic sdoOe;
	logic [7:0] sampleCode;
	gdc_pkg::gdc_analog_ctrl_t analogCtrl;
	logic irqRequestN;
	logic readySeen;
	logic [31:0] rdSeen;
	logic [31:0] seed = 32'h00014FFD;
	logic [31:0] r;
	logic [2:0] sel;
	logic diff;
	int errCount = 0;
	int compares = 0;
	int n;

	// Free-running 200 MHz clock.
	always #2.5 clk = ~clk;

	// What the master sees at the next rising edge is settled by the falling edge.
	always @(negedge clk) begin
		readySeen = hreadyout;
		rdSeen = hrdata;
	end

	gdc_regs i_dut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe),
		.analogRouteEn(analogRouteEn), .chip_select_n(chipSelectN), .spiSdo(spiSdo),
		.spiSdoOe(spiSdoOe), .sdoOut(sdoOut), .sdoOe(sdoOe), .sampleCode(sampleCode),
		.analogCtrl(analogCtrl), .irqRequestN(irqRequestN));

	gdc_front_model i_front (.analogCtrl(analogCtrl), .gpioOut(gpioOut), .gpioOe(gpioOe),
		.pinDrive(pinDrive), .gpioIn(gpioIn), .sampleCode(sampleCode));

	// Prints the verdict and ends the run.
	task automatic testDone;
		if (errCount == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : testDone

	// The one comparison point of the bench.
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errCount++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// Waits for hready at a rising edge; a bus that never answers ends the run.
	task automatic waitReady;
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (readySeen !== 1'b1 && k < 20);
		if (readySeen !== 1'b1) begin
			errCount++;
			testDone();
		end
	endtask : waitReady

	// One single-word transfer: address phase, then data phase.
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
		output logic [31:0] rdv);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'h0};
		hwrite <= wr;
		htrans <= 2'h2;
		waitReady();
		htrans <= 2'h0;
		hwdata <= wd;
		waitReady();
		rdv = rdSeen;
	endtask : bus

	// Write and read shorthands.
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, idx, d, x);
	endtask : wr

	task automatic rd(input logic [7:0] idx, output logic [31:0] v);
		bus(1'b0, idx, 32'h0, v);
	endtask : rd

	// Linear feedback shift register step for repeatable random values.
	function automatic logic [31:0] nextRand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nextRand

	// Expected converter code for a configuration, as the front end forms it.
	function automatic logic [7:0] expCode(input logic [6:0] cfg, input logic [3:0] tr);
		logic d;
		d = cfg[6] && cfg[6:4] != 3'h7;
		return {cfg, d} ^ {tr, 4'h0};
	endfunction : expCode

	// Main sequence; each step sets inputs just after a rising edge.
	initial begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		rd(gdc_pkg::IDX_IOCFG, r);
		check(r, 32'h0);
		rd(gdc_pkg::IDX_CONVCFG, r);
		check(r, 32'h80);
		rd(8'h20, r);
		check(r, 32'h0);
		check(32'(hresp), 32'h0);
		// Direct outputs follow their bits, random patterns.
		wr(gdc_pkg::IDX_FSEL, 32'h000A0A0A);
		for (int i = 0; i < 8; i++) begin
			seed = nextRand(seed);
			wr(gdc_pkg::IDX_IOCFG, 32'(seed[2:0]));
			@(negedge clk);
			check(32'({gpioOe, gpioOut}), 32'({3'h7, seed[2:0]}));
		end
		// Direct inputs read back the pin level.
		wr(gdc_pkg::IDX_FSEL, 32'h00020202);
		for (int i = 0; i < 8; i++) begin
			seed = nextRand(seed);
			pinDrive <= seed[2:0];
			@(posedge clk);
			rd(gdc_pkg::IDX_IOCFG, r);
			check(r & 32'h7, 32'(seed[2:0]));
		end
		// Falling, rising and any-change sources; each flags its own edge and pins left unchanged stay clear.
		pinDrive <= 3'h1;
		wr(gdc_pkg::IDX_FSEL, 32'h00060504);
		rd(gdc_pkg::IDX_IOCFG, r);
		wr(gdc_pkg::IDX_IRQSTAT, 32'hF);
		pinDrive <= 3'h2;
		repeat (3) @(posedge clk);
		rd(gdc_pkg::IDX_IOCFG, r);
		check((r >> 4) & 32'h7, 32'h3);
		pinDrive <= 3'h6;
		repeat (3) @(posedge clk);
		rd(gdc_pkg::IDX_IOCFG, r);
		check((r >> 4) & 32'h7, 32'h4);
		rd(gdc_pkg::IDX_IRQSTAT, r);
		check(r, 32'h7);
		// Masking and clearing of the interrupt line.
		@(negedge clk);
		check(32'(irqRequestN), 32'h1);
		wr(gdc_pkg::IDX_IRQMASK, 32'h1);
		@(negedge clk);
		check(32'(irqRequestN), 32'h0);
		wr(gdc_pkg::IDX_IRQSTAT, 32'h1);
		@(negedge clk);
		check(32'(irqRequestN), 32'h1);
		// Interrupt shown on serial out only while the select is idle.
		wr(gdc_pkg::IDX_IRQMASK, 32'h2);
		wr(gdc_pkg::IDX_IOCFG, 32'h8);
		@(negedge clk);
		check(32'({sdoOe, sdoOut}), 32'h2);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			seed = nextRand(seed);
			chipSelectN <= seed[2];
			spiSdo <= seed[0];
			spiSdoOe <= seed[1];
			@(negedge clk);
			check(32'({sdoOe, sdoOut}), seed[2] ? 32'h2 : 32'(seed[1:0]));
		end
		wr(gdc_pkg::IDX_IRQSTAT, 32'hF);
		// Only the done event is unmasked, so the line tells of each finished cycle.
		wr(gdc_pkg::IDX_IRQMASK, 32'h8);
		// Conversions over every input code with random reference, gain and trim.
		wr(gdc_pkg::IDX_FSEL, 32'h00070707);
		@(negedge clk);
		check(32'(analogRouteEn), 32'h7);
		for (int i = 0; i < 8; i++) begin
			seed = nextRand(seed);
			sel = 3'(i);
			diff = sel[2] && sel != 3'h7;
			wr(gdc_pkg::IDX_TRIM, {24'h0, seed[11:4]});
			rd(gdc_pkg::IDX_TRIM, r);
			check(r, 32'(seed[7:4]));
			wr(gdc_pkg::IDX_CONVCFG, {24'h0, 1'b1, sel, seed[3:0]});
			rd(gdc_pkg::IDX_CONVCFG, r);
			check(r, 32'({sel, seed[3:0]}));
			check(32'(analogCtrl), 32'({sel, seed[3:0], seed[7:4], diff, !seed[3], seed[2]}));
			n = 0;
			do begin
				rd(gdc_pkg::IDX_CONVCFG, r);
				n++;
			end while (r[7] !== 1'b1 && n < 300);
			check(32'(r[7]), 32'h1);
			if (r[7] !== 1'b1) begin
				testDone();
			end
			rd(gdc_pkg::IDX_RESULT, r);
			check(r, 32'(expCode({sel, seed[3:0]}, seed[7:4])));
			wr(gdc_pkg::IDX_RESULT, ~r);
			wr(gdc_pkg::IDX_CONVCFG, {25'h0, ~sel, seed[3:0]});
			rd(gdc_pkg::IDX_RESULT, r);
			check(r, 32'(expCode({sel, seed[3:0]}, seed[7:4])));
			rd(gdc_pkg::IDX_IRQSTAT, r);
			check(r & 32'h8, 32'h8);
			check(32'(irqRequestN), 32'h0);
			wr(gdc_pkg::IDX_IRQSTAT, 32'h8);
		end
		testDone();
	end
endmodule : tb

`default_nettype wire
